// *** core/lccs_pkg.sv ***
package lccs_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_SETUP1 = 6'h01;
	localparam logic [5:0] IDX_SETUP3 = 6'h03;
	localparam logic [5:0] IDX_ACYC_RESET = 6'h05;
	localparam logic [5:0] IDX_SETUP4 = 6'h06;
	localparam logic [5:0] IDX_STATUS = 6'h0D;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;

	// reset values of the stored registers
	localparam logic [7:0] SETUP1_RST = 8'h03;
	localparam logic [7:0] SETUP3_RST = 8'h1F;
	localparam logic [7:0] SETUP4_RST = 8'h00;

	// setup register 1 fields
	localparam int S1_EN = 0;
	localparam int S1_CDS = 1;
	localparam int S1_MONO = 2;
	localparam int S1_MAX_SPEED = 6;
	// setup register 3 channel field
	localparam int S3_CHAN_LO = 6;
	// setup register 4 fields
	localparam int S4_LINE_COLOUR = 0;
	localparam int S4_AUTOCYCLE = 1;
	localparam int S4_FORCE_MUX = 2;
	localparam int S4_INTM_LO = 4;
	localparam int S4_FM_LO = 6;

	// colour codes for the input and offset/gain multiplexers
	localparam logic [1:0] COL_RED = 2'h0;
	localparam logic [1:0] COL_GREEN = 2'h1;
	localparam logic [1:0] COL_BLUE = 2'h2;

	localparam logic [2:0] PWR_ALL = 3'h7;
	localparam logic [2:0] PWR_RED = 3'h1;
	localparam logic [2:0] PWR_NONE = 3'h0;

	// auto-cycle state, one-hot
	typedef enum logic [2:0] {
		CYC_RED = 3'h1,
		CYC_GREEN = 3'h2,
		CYC_BLUE = 3'h4
	} lccs_cyc_t;

	// steering bundle driven towards the analogue front end
	typedef struct packed {
		logic [1:0] input_mux;
		logic [1:0] gain_sel;
		logic [2:0] chan_power;
		logic mono_active;
		logic cds_active;
	} lccs_path_t;

	localparam lccs_path_t PATH_RST = '{input_mux: COL_RED, gain_sel: COL_RED, chan_power: PWR_ALL,
		mono_active: 1'b0, cds_active: 1'b1};

endpackage

// *** core/lccs_rise.sv ***
module lccs_rise (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic pin_i,
	output logic rise_o
);
	logic prev_r;
	logic prev_nxt;

	// previous pin level; pin is synchronous to clk_i
	always_comb begin
		prev_nxt = ce_i ? pin_i : prev_r;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	// a high level held over many clocks is one pulse, not many
	assign rise_o = pin_i & ~prev_r;
endmodule

// *** core/lccs_cycler.sv ***
module lccs_cycler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic step_i,
	input wire logic clear_i,
	output logic [1:0] col_o,
	output logic [1:0] col_nxt_o
);
	import lccs_pkg::*;

	lccs_cyc_t state_r;
	lccs_cyc_t state_nxt;

	// clear wins over a step landing in the same cycle
	always_comb begin
		state_nxt = state_r;
		if (ce_i) begin
			if (clear_i) begin
				state_nxt = CYC_RED;
			end else if (step_i) begin
				unique case (state_r)
					CYC_RED: state_nxt = CYC_GREEN;
					CYC_GREEN: state_nxt = CYC_BLUE;
					CYC_BLUE: state_nxt = CYC_RED;
					default: state_nxt = CYC_RED;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= CYC_RED;
		end else begin
			state_r <= state_nxt;
		end
	end

	// colour code of a state
	function automatic logic [1:0] cyc_col(input lccs_cyc_t s);
		unique case (s)
			CYC_GREEN: cyc_col = COL_GREEN;
			CYC_BLUE: cyc_col = COL_BLUE;
			default: cyc_col = COL_RED;
		endcase
	endfunction

	assign col_o = cyc_col(state_r);
	assign col_nxt_o = cyc_col(state_nxt);
endmodule

// *** core/lccs_top.sv ***
// The register offsets and register access over Avalon-MM were left to the implementer.
module lccs_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [lccs_pkg::ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [lccs_pkg::DATA_W-1:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [lccs_pkg::DATA_W-1:0] readdata_o,
	output logic waitrequest_o,
	input wire logic cycle_clamp_pin_i,
	output lccs_pkg::lccs_path_t path_o
);
	import lccs_pkg::*;

	logic [REG_W-1:0] setup1_r, setup1_nxt;
	logic [REG_W-1:0] setup3_r, setup3_nxt;
	logic [REG_W-1:0] setup4_r, setup4_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic wait_r, wait_nxt;
	lccs_path_t path_r, path_nxt;
	logic [5:0] idx;
	logic accept;
	logic wr_acc;
	logic acyc_clear;
	logic rise;
	logic step;
	logic [1:0] cyc_col;
	logic [1:0] cyc_col_nxt;

	// map a two-bit colour field; the unused code falls back to red
	function automatic logic [1:0] col_sel(input logic [1:0] code);
		col_sel = (code == COL_BLUE || code == COL_GREEN) ? code : COL_RED;
	endfunction

	// word index of the bus address
	function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
		word_idx = a[ADDR_W-1:ADDR_LSB];
	endfunction

	// full steering decode from register values and cycle colour
	function automatic lccs_path_t steer(input logic [REG_W-1:0] s1, input logic [REG_W-1:0] s3,
			input logic [REG_W-1:0] s4, input logic [1:0] cyc);
		lccs_path_t p;
		logic [1:0] intm;
		logic [1:0] fm;
		intm = col_sel(s4[S4_INTM_LO +: 2]);
		fm = col_sel(s4[S4_FM_LO +: 2]);
		p.cds_active = s1[S1_CDS] & ~s1[S1_MAX_SPEED];
		if (s4[S4_LINE_COLOUR]) begin
			// only red path is live in line colour operation
			p.chan_power = s1[S1_EN] ? PWR_RED : PWR_NONE;
			p.mono_active = 1'b1;
			unique case ({s4[S4_FORCE_MUX], s4[S4_AUTOCYCLE]})
				2'b00: begin
					p.input_mux = intm;
					p.gain_sel = intm;
				end
				2'b01: begin
					p.input_mux = cyc;
					p.gain_sel = cyc;
				end
				2'b10: begin
					p.input_mux = fm;
					p.gain_sel = intm;
				end
				default: begin
					p.input_mux = fm;
					p.gain_sel = cyc;
				end
			endcase
		end else begin
			// channel bits pick the input; the controller rewrites them per line
			p.chan_power = s1[S1_EN] ? PWR_ALL : PWR_NONE;
			p.mono_active = s1[S1_MONO];
			p.input_mux = col_sel(s3[S3_CHAN_LO +: 2]);
			p.gain_sel = col_sel(s3[S3_CHAN_LO +: 2]);
		end
		steer = p;
	endfunction

	assign idx = word_idx(address_i);
	assign accept = ce_i & ~wait_r & (read_i | write_i);
	assign wr_acc = accept & write_i;
	// any byte lanes count: the write itself is the event
	assign acyc_clear = wr_acc & (idx == IDX_ACYC_RESET);

	lccs_rise u_rise (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i(cycle_clamp_pin_i),
		.rise_o(rise)
	);

	// cycling only runs in line colour mode with the cycle bit set
	assign step = rise & setup4_r[S4_LINE_COLOUR] & setup4_r[S4_AUTOCYCLE];

	lccs_cycler u_cycler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.step_i(step),
		.clear_i(acyc_clear),
		.col_o(cyc_col),
		.col_nxt_o(cyc_col_nxt)
	);

	// bus slave: one wait cycle, then a single-cycle acceptance
	always_comb begin
		setup1_nxt = setup1_r;
		setup3_nxt = setup3_r;
		setup4_nxt = setup4_r;
		rdata_nxt = rdata_r;
		wait_nxt = wait_r;
		if (ce_i) begin
			wait_nxt = ~((read_i | write_i) & wait_r);
			if (read_i & wait_r) begin
				unique case (idx)
					IDX_SETUP1: rdata_nxt = {{(DATA_W-REG_W){1'b0}}, setup1_r};
					IDX_SETUP3: rdata_nxt = {{(DATA_W-REG_W){1'b0}}, setup3_r};
					IDX_SETUP4: rdata_nxt = {{(DATA_W-REG_W){1'b0}}, setup4_r};
					IDX_STATUS: rdata_nxt = {{(DATA_W-$bits(lccs_path_t)){1'b0}}, path_r};
					default: rdata_nxt = '0;
				endcase
			end
			if (wr_acc & byteenable_i[0]) begin
				unique case (idx)
					IDX_SETUP1: setup1_nxt = writedata_i[REG_W-1:0];
					IDX_SETUP3: setup3_nxt = writedata_i[REG_W-1:0];
					IDX_SETUP4: setup4_nxt = writedata_i[REG_W-1:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			setup1_r <= SETUP1_RST;
			setup3_r <= SETUP3_RST;
			setup4_r <= SETUP4_RST;
			rdata_r <= '0;
			wait_r <= 1'b1;
		end else begin
			setup1_r <= setup1_nxt;
			setup3_r <= setup3_nxt;
			setup4_r <= setup4_nxt;
			rdata_r <= rdata_nxt;
			wait_r <= wait_nxt;
		end
	end

	// steering built from next values so outputs track registers without lag
	always_comb begin
		path_nxt = steer(setup1_nxt, setup3_nxt, setup4_nxt, cyc_col_nxt);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			path_r <= PATH_RST;
		end else begin
			path_r <= path_nxt;
		end
	end

	assign readdata_o = rdata_r;
	assign waitrequest_o = wait_r;
	assign path_o = path_r;

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic lbl, acyc, force_mux_enable;
	assign lbl = setup4_r[S4_LINE_COLOUR];
	assign acyc = setup4_r[S4_AUTOCYCLE];
	assign force_mux_enable = setup4_r[S4_FORCE_MUX];

	lbl_power_a: assert property (lbl |-> path_r.chan_power[2:1] == 2'b00 && path_r.mono_active)
		else $error("line colour mode left green or blue powered or not mono");
	chan_select_a: assert property (!lbl |-> path_r.input_mux == col_sel(setup3_r[S3_CHAN_LO +: 2]))
		else $error("input mux does not follow channel bits");
	cycle_step_a: assert property (ce_i && step && !acyc_clear |=> cyc_col != $past(cyc_col))
		else $error("cycle pin pulse did not step the cycled colour");
	pulse_adv_a: assert property (ce_i && step && !acyc_clear && !(wr_acc && idx == IDX_SETUP4)
			|=> path_r.gain_sel != $past(path_r.gain_sel))
		else $error("cycle pulse did not advance gain select");
	acyc_reset_a: assert property (acyc_clear |=> cyc_col == COL_RED ##0 (!(lbl && acyc) || path_r.gain_sel == COL_RED))
		else $error("auto-cycle reset did not return to red");
	internal_sel_a: assert property (lbl && !force_mux_enable && !acyc
			|-> path_r.input_mux == col_sel(setup4_r[S4_INTM_LO +: 2]) && path_r.gain_sel == path_r.input_mux)
		else $error("internal colour select not applied");
	cyc_together_a: assert property (lbl && !force_mux_enable && acyc |-> path_r.input_mux == cyc_col && path_r.gain_sel == cyc_col)
		else $error("input and gain not cycling together");
	forced_int_a: assert property (lbl && force_mux_enable && !acyc |-> path_r.input_mux == col_sel(setup4_r[S4_FM_LO +: 2])
			&& path_r.gain_sel == col_sel(setup4_r[S4_INTM_LO +: 2]))
		else $error("forced input with internal gain not applied");
	forced_cyc_a: assert property (lbl && force_mux_enable && acyc |-> path_r.input_mux == col_sel(setup4_r[S4_FM_LO +: 2])
			&& path_r.gain_sel == cyc_col)
		else $error("forced input with cycled gain not applied");
	no_cds_a: assert property (setup1_r[S1_MAX_SPEED] |-> !path_r.cds_active)
		else $error("cds active in maximum speed mode");
	bus_answer_a: assert property (ce_i && (read_i || write_i) && wait_r |=> !wait_r ##1 wait_r)
		else $error("bus answer not one cycle after request");

	cyc_wrap_c: cover property (lbl && acyc && cyc_col == COL_BLUE ##[1:50] cyc_col == COL_RED);
	acyc_clear_c: cover property (acyc_clear && cyc_col != COL_RED);
	forced_cyc_c: cover property (lbl && force_mux_enable && acyc && step);
	status_read_c: cover property (accept && read_i && idx == IDX_STATUS);
endmodule

// *** bench/lccs_scan_model.sv ***
// scanner controller side: drives the cycle pin, one pulse per request
module lccs_scan_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [1:0] hold_i,
	output logic cycle_clamp_pin_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] cnt_r = 3'h0;
	// pin stays high hold_i+1 cycles, always low a cycle before the next pulse
	always @(posedge clk_i) begin
		if (go_i && cnt_r == 3'h0) begin
			cnt_r <= {1'b0, hold_i} + 3'h1;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
	assign cycle_clamp_pin_o = (cnt_r != 3'h0);
endmodule

// *** bench/line_colour_channel_select_bench.sv ***
module line_colour_channel_select_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import lccs_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, read_i = 1'b0, write_i = 1'b0, go = 1'b0;
	logic [7:0] address_i = 8'h00, s1, s3, s4;
	logic [31:0] writedata_i = 32'h0, rd, v, readdata_o;
	logic [3:0] byteenable_i = 4'hF;
	logic [1:0] hold = 2'h0, cyc;
	logic waitrequest_o, pin;
	lccs_path_t path_o;
	int errors = 0, checks_done = 0, seed = 39536;
	logic [5:0] ri[4] = '{IDX_SETUP1, IDX_SETUP3, IDX_SETUP4, 6'h02};
	logic [7:0] rv[4] = '{SETUP1_RST, SETUP3_RST, SETUP4_RST, 8'h00};

	// free-running 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	lccs_top lccs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .cycle_clamp_pin_i(pin), .path_o(path_o));
	lccs_scan_model lccs_scan_model_inst (.clk_i(clk_i), .go_i(go), .hold_i(hold), .cycle_clamp_pin_o(pin));

	task end_of_test;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	// one avalon transfer; request held until waitrequest is seen low
	task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_i);
		address_i <= {idx, 2'b00};
		write_i <= wr;
		read_i <= !wr;
		writedata_i <= {24'h0, d};
		byteenable_i <= be;
		// waitrequest and read data are taken at the rising edge itself
		do begin
			@(posedge clk_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 20);
		if (waitrequest_o !== 1'b0) begin
			errors++;
			$display("BAD waitrequest exp 0 got 1");
			end_of_test;
		end
		rd = readdata_o;
		write_i <= 1'b0;
		read_i <= 1'b0;
	endtask

	// one pin pulse; only steps when line colour and cycling are both set
	task pulse(input logic [1:0] h);
		@(posedge clk_i);
		go <= 1'b1;
		hold <= h;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (6) @(posedge clk_i);
		if (s4[0] && s4[1]) cyc = (cyc == 2'h2) ? 2'h0 : cyc + 2'h1;
	endtask

	// unused colour code 11 falls back to red
	function automatic logic [1:0] fix(input logic [1:0] c);
		return (c == 2'h3) ? COL_RED : c;
	endfunction

	function automatic lccs_path_t expect_path(input logic [7:0] a, b, c, input logic [1:0] y);
		lccs_path_t p;
		p.input_mux = !c[0] ? fix(b[7:6]) : c[2] ? fix(c[7:6]) : c[1] ? y : fix(c[5:4]);
		p.gain_sel = !c[0] ? fix(b[7:6]) : c[1] ? y : fix(c[5:4]);
		p.chan_power = !a[0] ? PWR_NONE : c[0] ? PWR_RED : PWR_ALL;
		p.mono_active = a[2] | c[0];
		p.cds_active = a[1] & !a[6];
		return p;
	endfunction

	// reset values, then random configurations mixed with pulses and cycle resets
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check("path_rst", 32'(PATH_RST), 32'(path_o));
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, ri[i], 8'h00, 4'hF);
			check("reg_rst", {24'h0, rv[i]}, rd);
		end
		s1 = SETUP1_RST;
		s3 = SETUP3_RST;
		cyc = 2'h0;
		for (int k = 0; k < 80; k++) begin
			v = $random(seed);
			s1 = v[7:0];
			if (v[30]) s1[0] = 1'b1;
			s3 = v[15:8];
			s4 = v[23:16];
			if (v[29]) s4[1:0] = 2'h3;
			bus(1'b1, IDX_SETUP4, {s4[7:1], 1'b1}, 4'hF);
			bus(1'b1, IDX_SETUP1, s1, 4'hF);
			bus(1'b1, IDX_SETUP3, s3, 4'hF);
			bus(1'b1, IDX_SETUP4, s4, 4'hF);
			if (v[24]) begin
				bus(1'b1, IDX_ACYC_RESET, v[7:0], v[25] ? 4'hF : 4'h0);
				cyc = COL_RED;
			end
			if (v[26]) bus(1'b1, IDX_SETUP4, ~s4, 4'h0);
			repeat (v[28:27]) pulse(v[10:9]);
			@(negedge clk_i);
			check("path", 32'(expect_path(s1, s3, s4, cyc)), 32'(path_o));
			bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
			check("status", 32'(expect_path(s1, s3, s4, cyc)), rd);
			bus(1'b0, IDX_SETUP4, 8'h00, 4'hF);
			check("setup4", {24'h0, s4}, rd);
		end
		// clock enable low: a pin pulse must not step the cycle
		s4 = 8'h03;
		bus(1'b1, IDX_SETUP4, s4, 4'hF);
		@(posedge clk_i);
		ce_i <= 1'b0;
		@(posedge clk_i);
		go <= 1'b1;
		hold <= 2'h1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (6) @(posedge clk_i);
		ce_i <= 1'b1;
		@(negedge clk_i);
		check("path_ce", 32'(expect_path(s1, s3, s4, cyc)), 32'(path_o));
		end_of_test;
	end
endmodule
